/* logic/atc_top.sv */
`timescale 1ns/1ns
`include "atc_consts.svh"

// Function
// - Five independent 32-bit timers: astable, two monostables, delay, events.
// - Astable period set in 1 us steps from 1 us to 70 minutes.
// - Astable pulse serves as monostable source or as acquisition trigger.
// - Two monostables share one selected trigger, each with its own width.
// - Trigger delay counts microseconds or received lines, chosen by config.
// - A pending delay is never restarted; later triggers are dropped.
// - Event counter counts lines, frames or microseconds.
// - Count only inside the chosen gate: line, frame, trigger, acquisition.
// - Both the live count and the previous gate's final count are readable.
// - Each camera control bit is a static level or an exposure pulse.
// - Each isolated output is software level, timer or routed trigger.
// - Isolated port has two inputs and two outputs.
// - Differential inputs act as trigger sources or encoder inputs.
// - Each 8-bit TTL port switches direction as a whole.
// - One interrupt output rises on any enabled event source.
// - Trigger is level or edge sensitive on one selected input.
// - Latch enable low reads live pins; its rising edge freezes them.
module atc_top
   import atc_pkg::*;
#(
   parameter int CW  = `ATC_CNT_W,
   parameter int TTW = `ATC_TTL_W
) (
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   line_valid_in,
   input  wire logic                   frame_valid_in,
   input  wire logic                   acq_active,
   input  wire logic [`ATC_ISO_W-1:0]  isolated_input_a,
   input  wire logic [`ATC_DIFF_W-1:0] diff_trigger_input,
   input  wire logic [TTW-1:0]         ttl_a_in,
   input  wire logic [TTW-1:0]         ttl_b_in,
   input  wire logic [1:0]             ttl_latch_en,
   input  wire atc_trig_cfg_t          trig_cfg,
   input  wire logic                   astable_en,
   input  wire logic [CW-1:0]          astable_period,
   input  wire atc_mono_src_t          mono_src,
   input  wire logic                   mono_sw_fire,
   input  wire logic [CW-1:0]          mono_width0,
   input  wire logic [CW-1:0]          mono_width1,
   input  wire logic [CW-1:0]          delay_value,
   input  wire atc_evt_cfg_t           evt_cfg,
   input  wire logic [`ATC_CC_W-1:0]   cc_pulse_mode,
   input  wire logic [`ATC_CC_W-1:0]   cc_pulse_sel,
   input  wire logic [`ATC_CC_W-1:0]   cc_level,
   input  wire atc_iso_src_t           iso_src0,
   input  wire atc_iso_src_t           iso_src1,
   input  wire logic [`ATC_ISO_W-1:0]  iso_level,
   input  wire logic [1:0]             diff_encoder_mode,
   input  wire logic [1:0]             ttl_dir_out,
   input  wire logic [TTW-1:0]         ttl_a_wr,
   input  wire logic [TTW-1:0]         ttl_b_wr,
   input  wire logic [5:0]             irq_events,
   input  wire logic [5:0]             irq_enable,
   output logic [`ATC_CC_W-1:0]        camera_control_bit_r,
   output logic [`ATC_ISO_W-1:0]       isolated_output_a_r,
   output logic                        acq_trigger_r,
   output logic                        trig_pending_r,
   output logic [1:0]                  encoder_step_r,
   output logic [CW-1:0]               evt_live_r,
   output logic [CW-1:0]               evt_final_r,
   output logic [TTW-1:0]              ttl_a_out_r,
   output logic [TTW-1:0]              ttl_b_out_r,
   output logic [1:0]                  ttl_oe_n_r,
   output logic [TTW-1:0]              ttl_a_rd_r,
   output logic [TTW-1:0]              ttl_b_rd_r,
   output logic                        irq_r
);

   localparam int SW    = 2 + `ATC_ISO_W + `ATC_DIFF_W + 2 * TTW + 2;
   localparam int TICKC = `ATC_TICK_CYCLES;
   localparam logic [CW-1:0] AST_MAX = CW'(`ATC_ASTABLE_MAX_US);

   logic [SW-1:0]        pin_s1_r, pin_s2_r, pin_d_r;
   logic                 lval, fval, lval_rise, fval_rise, fval_fall;
   logic [`ATC_ISO_W-1:0]  iso_in;
   logic [`ATC_DIFF_W-1:0] diff_in, diff_rise;
   logic [TTW-1:0]       ttl_a_pin, ttl_b_pin;
   logic [1:0]           len, len_rise;
   logic [5:0]           trig_lvls, trig_rise;
   logic [4:0]           us_cnt_r;
   logic                 us_tick_r;
   logic                 ast_busy, ast_done, mono_fire;
   logic [1:0]           mono_busy;
   logic [CW-1:0]        ast_load;
   logic                 raw_evt, dly_done, dly_busy, dly_tick;
   logic                 trig_out, envelope;
   atc_dly_state_t       dly_state_r;
   logic                 gate, gate_d_r, evt_pulse;

   // Two-stage synchroniser for every pin input
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_d_r  <= '0;
      end else begin
         pin_s1_r <= {line_valid_in, frame_valid_in, isolated_input_a,
                      diff_trigger_input, ttl_a_in, ttl_b_in, ttl_latch_en};
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
      end
   end

   // Unpack synchronised pins and their rising edges
   assign {lval, fval, iso_in, diff_in, ttl_a_pin, ttl_b_pin, len} = pin_s2_r;
   assign lval_rise = lval & ~pin_d_r[SW-1];
   assign fval_rise = fval & ~pin_d_r[SW-2];
   assign fval_fall = ~fval & pin_d_r[SW-2];
   assign diff_rise = diff_in & ~pin_d_r[2*TTW+2 +: `ATC_DIFF_W];
   assign len_rise  = len & ~pin_d_r[1:0];
   assign trig_lvls = {diff_in, iso_in};
   assign trig_rise = {diff_rise,
                       iso_in & ~pin_d_r[`ATC_DIFF_W+2*TTW+2 +: `ATC_ISO_W]};

   // Microsecond prescaler
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         us_cnt_r  <= '0;
         us_tick_r <= 1'b0;
      end else begin
         us_tick_r <= (us_cnt_r == 5'(TICKC - 1));
         us_cnt_r  <= (us_cnt_r == 5'(TICKC - 1)) ? '0 : us_cnt_r + 5'd1;
      end
   end

   // Astable: reloads seamlessly so every period after the first is exact
   assign ast_load = (astable_period > AST_MAX) ? AST_MAX : astable_period;
   atc_timer #(.WIDTH(CW), .RETRIG(1'b0)) u_astable (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick     (us_tick_r),
      .start    (astable_en && !ast_busy),
      .reload   (astable_en),
      .load_val (ast_load),
      .busy_r   (ast_busy),
      .done_r   (ast_done),
      .count_r  ()
   );

   // Trigger qualification: level or edge, or the astable pulse
   assign raw_evt = trig_cfg.use_astable ? ast_done :
                    trig_cfg.edge_mode ? trig_rise[trig_cfg.src] :
                    trig_lvls[trig_cfg.src];
   assign envelope = trig_lvls[trig_cfg.src];

   // Delay counts microseconds or lines
   assign dly_tick = trig_cfg.delay_lines ? lval_rise : us_tick_r;
   atc_timer #(.WIDTH(CW), .RETRIG(1'b0)) u_delay (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick     (dly_tick),
      .start    (trig_cfg.delay_en && raw_evt
                 && dly_state_r == ATC_DLY_IDLE),
      .reload   (1'b0),
      .load_val (delay_value),
      .busy_r   (dly_busy),
      .done_r   (dly_done),
      .count_r  ()
   );

   // Pending state; further events are ignored until expiry
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dly_state_r <= ATC_DLY_IDLE;
      end else begin
         case (dly_state_r)
            ATC_DLY_IDLE: begin
               if (trig_cfg.delay_en && raw_evt) begin
                  dly_state_r <= ATC_DLY_PEND;
               end
            end
            ATC_DLY_PEND: begin
               if (dly_done) begin
                  dly_state_r <= ATC_DLY_IDLE;
               end
            end
            default: dly_state_r <= ATC_DLY_IDLE;
         endcase
      end
   end

   assign trig_out = trig_cfg.delay_en ? dly_done : raw_evt;

   // Acquisition trigger and pending flag
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acq_trigger_r  <= 1'b0;
         trig_pending_r <= 1'b0;
      end else begin
         acq_trigger_r  <= trig_out;
         trig_pending_r <= dly_busy;
      end
   end

   // Two exposure monostables from one common source
   assign mono_fire = (mono_src == ATC_MONO_ASTABLE) ? ast_done :
                      (mono_src == ATC_MONO_TRIG) ? trig_out :
                      (mono_src == ATC_MONO_SW) ? mono_sw_fire : 1'b0;

   atc_timer #(.WIDTH(CW), .RETRIG(1'b1)) u_mono0 (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick     (us_tick_r),
      .start    (mono_fire),
      .reload   (1'b0),
      .load_val (mono_width0),
      .busy_r   (mono_busy[0]),
      .done_r   (),
      .count_r  ()
   );

   atc_timer #(.WIDTH(CW), .RETRIG(1'b1)) u_mono1 (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick     (us_tick_r),
      .start    (mono_fire),
      .reload   (1'b0),
      .load_val (mono_width1),
      .busy_r   (mono_busy[1]),
      .done_r   (),
      .count_r  ()
   );

   // Gate and event selection
   always_comb begin
      case (evt_cfg.gate)
         ATC_GATE_LINE:  gate = lval;
         ATC_GATE_FRAME: gate = fval;
         ATC_GATE_TRIG:  gate = envelope;
         ATC_GATE_ACQ:   gate = acq_active;
         default:        gate = 1'b0;
      endcase
      case (evt_cfg.evt_type)
         ATC_EVT_LINE:  evt_pulse = lval_rise;
         ATC_EVT_FRAME: evt_pulse = fval_rise;
         ATC_EVT_USEC:  evt_pulse = us_tick_r;
         default:       evt_pulse = 1'b0;
      endcase
   end

   // Live count restarts on gate open; final count caught on close
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate_d_r    <= 1'b0;
         evt_live_r  <= `ATC_RST_CNT;
         evt_final_r <= `ATC_RST_CNT;
      end else begin
         gate_d_r <= gate;
         if (gate && !gate_d_r) begin
            evt_live_r <= CW'(evt_pulse);
         end else if (gate && evt_pulse) begin
            evt_live_r <= evt_live_r + CW'(1);
         end
         if (!gate && gate_d_r) begin
            evt_final_r <= evt_live_r;
         end
      end
   end

   // Camera control and isolated outputs
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         camera_control_bit_r <= '0;
         isolated_output_a_r  <= '0;
      end else begin
         for (int i = 0; i < `ATC_CC_W; i++) begin
            camera_control_bit_r[i] <= cc_pulse_mode[i] ?
               mono_busy[cc_pulse_sel[i]] : cc_level[i];
         end
         for (int j = 0; j < `ATC_ISO_W; j++) begin
            case ((j == 0) ? iso_src0 : iso_src1)
               ATC_ISO_SW:    isolated_output_a_r[j] <= iso_level[j];
               ATC_ISO_EXPO0: isolated_output_a_r[j] <= mono_busy[0];
               ATC_ISO_EXPO1: isolated_output_a_r[j] <= mono_busy[1];
               ATC_ISO_TRIG:  isolated_output_a_r[j] <= trig_out;
               default:       isolated_output_a_r[j] <= 1'b0;
            endcase
         end
      end
   end

   // Encoder steps on the first line of each differential pair
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         encoder_step_r <= '0;
      end else begin
         encoder_step_r <= diff_encoder_mode
                           & {diff_rise[2], diff_rise[0]};
      end
   end

   // TTL drive: enable low while driving
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ttl_a_out_r <= `ATC_RST_TTL;
         ttl_b_out_r <= `ATC_RST_TTL;
         ttl_oe_n_r  <= `ATC_RST_OE_N;
      end else begin
         ttl_a_out_r <= ttl_a_wr;
         ttl_b_out_r <= ttl_b_wr;
         ttl_oe_n_r  <= ~ttl_dir_out;
      end
   end

   // TTL readback: live while latch low, frozen from its rising edge
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ttl_a_rd_r <= `ATC_RST_TTL;
         ttl_b_rd_r <= `ATC_RST_TTL;
      end else begin
         if (!len[1] || len_rise[1]) begin
            ttl_a_rd_r <= ttl_a_pin;
         end
         if (!len[0] || len_rise[0]) begin
            ttl_b_rd_r <= ttl_b_pin;
         end
      end
   end

   // Single interrupt line
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_events & irq_enable);
      end
   end

endmodule // atc_top

/* logic/atc_consts.svh */
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// Timebase
`define ATC_CLK_PERIOD_NS   50
`define ATC_TICK_NS         1000
`define ATC_TICK_CYCLES     (`ATC_TICK_NS / `ATC_CLK_PERIOD_NS)

// Astable limit, 70 minutes in microseconds
`define ATC_ASTABLE_MAX_MIN 70
`define ATC_ASTABLE_MAX_US  (`ATC_ASTABLE_MAX_MIN * 60 * 64'd1000000)

// Port widths
`define ATC_CNT_W           32
`define ATC_CC_W            4
`define ATC_ISO_W           2
`define ATC_DIFF_W          4
`define ATC_TTL_W           8

// Reset values
`define ATC_RST_CNT         32'h0000_0000
`define ATC_RST_TTL         8'h00
`define ATC_RST_OE_N        2'h3

`endif

/* logic/atc_pkg.sv */
package atc_pkg;

   typedef enum logic [1:0] {
      ATC_EVT_LINE  = 2'b00,
      ATC_EVT_FRAME = 2'b01,
      ATC_EVT_USEC  = 2'b10
   } atc_evt_t;

   typedef enum logic [1:0] {
      ATC_GATE_LINE  = 2'b00,
      ATC_GATE_FRAME = 2'b01,
      ATC_GATE_TRIG  = 2'b10,
      ATC_GATE_ACQ   = 2'b11
   } atc_gate_t;

   typedef enum logic [1:0] {
      ATC_ISO_SW    = 2'b00,
      ATC_ISO_EXPO0 = 2'b01,
      ATC_ISO_EXPO1 = 2'b10,
      ATC_ISO_TRIG  = 2'b11
   } atc_iso_src_t;

   typedef enum logic [1:0] {
      ATC_MONO_ASTABLE = 2'b00,
      ATC_MONO_TRIG    = 2'b01,
      ATC_MONO_SW      = 2'b10
   } atc_mono_src_t;

   typedef enum logic {
      ATC_DLY_IDLE = 1'b0,
      ATC_DLY_PEND = 1'b1
   } atc_dly_state_t;

   typedef struct packed {
      logic [2:0] src;         // 0..1 isolated inputs, 2..5 diff inputs
      logic       edge_mode;   // 1 edge, 0 level
      logic       use_astable; // astable drives the trigger
      logic       delay_en;
      logic       delay_lines; // 1 count lines, 0 count microseconds
   } atc_trig_cfg_t;

   typedef struct packed {
      atc_evt_t  evt_type;
      atc_gate_t gate;
   } atc_evt_cfg_t;

endpackage

/* logic/atc_timer.sv */
`timescale 1ns/1ns
`include "atc_consts.svh"

module atc_timer #(
   parameter int WIDTH  = `ATC_CNT_W,
   parameter bit RETRIG = 1'b1
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             tick,
   input  wire logic             start,
   input  wire logic             reload,
   input  wire logic [WIDTH-1:0] load_val,
   output logic                  busy_r,
   output logic                  done_r,
   output logic [WIDTH-1:0]      count_r
);
   import atc_pkg::*;

   logic [WIDTH-1:0] load_eff;
   logic             last;

   // Zero is taken as the shortest interval, one tick
   assign load_eff = (load_val == '0) ? WIDTH'(1) : load_val;
   assign last     = busy_r && tick && (count_r == WIDTH'(1));

   // Down counter with optional seamless reload
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= '0;
         busy_r  <= 1'b0;
      end else if (start && (!busy_r || RETRIG)) begin
         count_r <= load_eff;
         busy_r  <= 1'b1;
      end else if (last) begin
         count_r <= reload ? load_eff : '0;
         busy_r  <= reload;
      end else if (busy_r && tick) begin
         count_r <= count_r - WIDTH'(1);
      end
   end

   // One-cycle expiry pulse
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= last;
      end
   end

endmodule // atc_timer

/* verif/atc_top_asserts.sv */
`timescale 1ns/1ns
`include "atc_consts.svh"
// Port-level checks on the timer and I/O block
module atc_top_asserts
   import atc_pkg::*;
#(
   parameter int CW = `ATC_CNT_W
) (
   input wire logic                  core_clk,
   input wire logic                  sys_rst,
   input wire atc_trig_cfg_t         trig_cfg,
   input wire logic [CW-1:0]         delay_value,
   input wire logic [`ATC_CC_W-1:0]  cc_pulse_mode,
   input wire logic [`ATC_CC_W-1:0]  cc_level,
   input wire atc_iso_src_t          iso_src0,
   input wire logic [`ATC_ISO_W-1:0] iso_level,
   input wire logic [1:0]            ttl_dir_out,
   input wire logic [7:0]            ttl_a_wr,
   input wire logic [5:0]            irq_events,
   input wire logic [5:0]            irq_enable,
   input wire logic [`ATC_CC_W-1:0]  camera_control_bit_r,
   input wire logic [`ATC_ISO_W-1:0] isolated_output_a_r,
   input wire logic                  acq_trigger_r,
   input wire logic                  trig_pending_r,
   input wire logic [1:0]            encoder_step_r,
   input wire logic [CW-1:0]         evt_live_r,
   input wire logic [CW-1:0]         evt_final_r,
   input wire logic [7:0]            ttl_a_out_r,
   input wire logic [1:0]            ttl_oe_n_r,
   input wire logic                  irq_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic rst_d;
   // Masks the first edge after reset release
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) rst_d <= 1'h1;
      else rst_d <= 1'h0;
   end
   AST_CC_LEVEL: assert property (!rst_d
      |-> ((camera_control_bit_r ^ $past(cc_level))
      & ~$past(cc_pulse_mode)) == 4'h0)
      else $error("camera bit not at static level");
   AST_ISO_SW: assert property (!rst_d && $past(iso_src0) == ATC_ISO_SW
      |-> isolated_output_a_r[0] == $past(iso_level[0]))
      else $error("isolated output not at software level");
   AST_TTL_OE: assert property (!rst_d
      |-> ttl_oe_n_r == ~$past(ttl_dir_out))
      else $error("ttl enable wrong");
   AST_TTL_OUT: assert property (!rst_d && $past(ttl_dir_out[1])
      |-> ttl_a_out_r == $past(ttl_a_wr))
      else $error("ttl drive value wrong");
   AST_IRQ: assert property (!rst_d
      |-> irq_r == |($past(irq_events) & $past(irq_enable)))
      else $error("interrupt output wrong");
   AST_DLY_MIN: assert property (trig_cfg.delay_en
      && !trig_cfg.delay_lines && delay_value > 32'h1
      && $rose(trig_pending_r) |-> trig_pending_r[*8])
      else $error("time delay ended too early");
   AST_PEND_QUIET: assert property (trig_cfg.edge_mode
      && trig_pending_r && $past(trig_pending_r)
      && $past(trig_pending_r, 2) |-> !acq_trigger_r)
      else $error("trigger while delay pending");
   AST_TRIG_EDGE: assert property (trig_cfg.edge_mode
      && acq_trigger_r |=> !acq_trigger_r)
      else $error("edge trigger longer than one cycle");
   AST_ENC_PULSE: assert property (encoder_step_r[0]
      |=> !encoder_step_r[0])
      else $error("encoder step too long");
   AST_EVT_FINAL: assert property (!rst_d && $changed(evt_final_r)
      |-> evt_final_r == $past(evt_live_r))
      else $error("final count not taken from live count");
endmodule // atc_top_asserts
bind atc_top atc_top_asserts #(.CW(CW)) i_asserts (.core_clk(core_clk),
   .sys_rst(sys_rst), .trig_cfg(trig_cfg), .delay_value(delay_value),
   .cc_pulse_mode(cc_pulse_mode), .cc_level(cc_level), .iso_src0(iso_src0),
   .iso_level(iso_level), .ttl_dir_out(ttl_dir_out), .ttl_a_wr(ttl_a_wr),
   .irq_events(irq_events), .irq_enable(irq_enable),
   .camera_control_bit_r(camera_control_bit_r),
   .isolated_output_a_r(isolated_output_a_r), .acq_trigger_r(acq_trigger_r),
   .trig_pending_r(trig_pending_r), .encoder_step_r(encoder_step_r),
   .evt_live_r(evt_live_r), .evt_final_r(evt_final_r),
   .ttl_a_out_r(ttl_a_out_r), .ttl_oe_n_r(ttl_oe_n_r), .irq_r(irq_r));

/* verif/atc_cam_model.sv */
`timescale 1ns/1ns
// Camera side: frame and line valid timing
module atc_cam_model (
   input  wire logic core_clk,
   output logic      lval,
   output logic      fval
);
   // Both valids idle low between frames
   initial begin
      lval = 1'h0;
      fval = 1'h0;
   end
   // One frame of n lines, changed only at falling edges
   task automatic frame(input int n);
      int i;
      @(negedge core_clk) fval = 1'h1;
      repeat (4) @(negedge core_clk);
      for (i = 0; i < n; i++) begin
         lval = 1'h1;
         repeat (6) @(negedge core_clk);
         lval = 1'h0;
         repeat (4) @(negedge core_clk);
      end
      fval = 1'h0;
      repeat (4) @(negedge core_clk);
   endtask
endmodule // atc_cam_model

/* verif/atc_tb_top.sv */
`timescale 1ns/1ns
module atc_tb_top;
   import atc_pkg::*;
   logic          core_clk = 1'h0;
   logic          sys_rst  = 1'h1;
   logic          lval, fval, acq, mfire, ast_en, trig, pend, irq;
   logic [1:0]    iso_in, isol, latch, encm, tdir, iso_o, enc, oen;
   logic [3:0]    diff, ccm, ccs, ccl, cc;
   logic [7:0]    pin_a, pin_b, pa_w, pb_w, twa, twb, oa, ob, ra, rb;
   logic [31:0]   per, w0, w1, dly, live, fin;
   logic [5:0]    irqe, irqn;
   atc_trig_cfg_t tcfg;
   atc_evt_cfg_t  ecfg;
   atc_mono_src_t msrc;
   atc_iso_src_t  is0, is1;
   int            mismatches = 0;
   int            check_count = 0;
   int            cyc = 0;
   atc_cam_model i_cam (.core_clk(core_clk), .lval(lval), .fval(fval));
   // Pin level seen by the port: DUT when driving, bench otherwise
   assign pa_w = oen[1] ? pin_a : oa;
   assign pb_w = oen[0] ? pin_b : ob;
   atc_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .line_valid_in(lval), .frame_valid_in(fval), .acq_active(acq),
      .isolated_input_a(iso_in), .diff_trigger_input(diff),
      .ttl_a_in(pa_w), .ttl_b_in(pb_w), .ttl_latch_en(latch),
      .trig_cfg(tcfg), .astable_en(ast_en), .astable_period(per),
      .mono_src(msrc), .mono_sw_fire(mfire), .mono_width0(w0),
      .mono_width1(w1), .delay_value(dly), .evt_cfg(ecfg),
      .cc_pulse_mode(ccm), .cc_pulse_sel(ccs), .cc_level(ccl),
      .iso_src0(is0), .iso_src1(is1), .iso_level(isol),
      .diff_encoder_mode(encm), .ttl_dir_out(tdir), .ttl_a_wr(twa),
      .ttl_b_wr(twb), .irq_events(irqe), .irq_enable(irqn),
      .camera_control_bit_r(cc), .isolated_output_a_r(iso_o),
      .acq_trigger_r(trig), .trig_pending_r(pend), .encoder_step_r(enc),
      .evt_live_r(live), .evt_final_r(fin), .ttl_a_out_r(oa),
      .ttl_b_out_r(ob), .ttl_oe_n_r(oen), .ttl_a_rd_r(ra),
      .ttl_b_rd_r(rb), .irq_r(irq));
   // 20 MHz clock
   always #25 core_clk = ~core_clk;
   // Compare one value
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Count trigger-high cycles over a fixed span
   task automatic cnt_trig(input int n, output int c, output int first);
      c = 0;
      first = -1;
      for (int i = 0; i < n; i++) begin
         @(negedge core_clk);
         if (trig === 1'h1 && first < 0) first = i;
         if (trig === 1'h1) c++;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic t_levels();
      ccm = 4'h0; ccl = 4'hA; is0 = ATC_ISO_SW; is1 = ATC_ISO_SW; isol = 2'h1;
      cyc_n(3);
      chk("cc level", 32'hA, cc);
      chk("iso level", 32'h1, iso_o);
      ccl = 4'h5; isol = 2'h2;
      cyc_n(3);
      chk("cc level", 32'h5, cc);
      chk("iso level", 32'h2, iso_o);
      $display("test levels done");
   endtask
   task automatic t_mono();
      int n0, n1, n2;
      n0 = 0; n1 = 0; n2 = 0;
      msrc = ATC_MONO_SW; w0 = 32'h3; w1 = 32'h5; ccm = 4'h3; ccs = 4'h2;
      is0 = ATC_ISO_EXPO0;
      cyc_n(2);
      mfire = 1'h1;
      cyc_n(1);
      mfire = 1'h0;
      repeat (200) begin
         @(negedge core_clk);
         n0 += cc[0];
         n1 += cc[1];
         n2 += iso_o[0];
      end
      chk("mono0 len ok", 32'h1, {31'h0, n0 > 39 && n0 <= 61});
      chk("mono1 len ok", 32'h1, {31'h0, n1 > 79 && n1 <= 101});
      chk("iso timer", n0, n2);
      ccm = 4'h0; is0 = ATC_ISO_SW;
      $display("test mono done");
   endtask
   task automatic t_astable();
      int c, f;
      tcfg.use_astable = 1'h1; per = 32'h2; ast_en = 1'h1;
      cnt_trig(60, c, f);
      cnt_trig(40, c, f);
      chk("astable pulses per 2us", 32'h1, c);
      per = 32'h1;
      cyc_n(60);
      cnt_trig(40, c, f);
      chk("astable pulses per 1us", 32'h2, c);
      ast_en = 1'h0; tcfg.use_astable = 1'h0;
      cyc_n(60);
      $display("test astable done");
   endtask
   task automatic t_delay();
      int c, f;
      tcfg.src = 3'h0; tcfg.edge_mode = 1'h1; tcfg.delay_en = 1'h1;
      tcfg.delay_lines = 1'h0; dly = 32'h3;
      cyc_n(2);
      iso_in[0] = 1'h1;
      fork
         begin
            cyc_n(10) ; iso_in[0] = 1'h0;
            cyc_n(10) ; iso_in[0] = 1'h1;
            cyc_n(10) ; iso_in[0] = 1'h0;
         end
      join_none
      cyc_n(25);
      chk("pending", 32'h1, pend);
      cnt_trig(120, c, f);
      chk("delayed triggers", 32'h1, c);
      chk("delay ok", 32'h1, {31'h0, f + 25 >= 42 && f + 25 <= 66});
      tcfg.src = 3'h1; tcfg.delay_lines = 1'h1; dly = 32'h2;
      iso_in[1] = 1'h1;
      cyc_n(6);
      chk("line pending", 32'h1, pend);
      fork
         i_cam.frame(3);
         cnt_trig(60, c, f);
      join
      chk("line triggers", 32'h1, c);
      iso_in[1] = 1'h0; tcfg.delay_en = 1'h0; tcfg.edge_mode = 1'h0;
      tcfg.src = 3'h2; is1 = ATC_ISO_TRIG;
      cyc_n(4);
      diff[0] = 1'h1;
      cnt_trig(10, c, f);
      diff[0] = 1'h0;
      chk("level trig", 32'h8, c);
      chk("iso trig", 32'h1, iso_o[1]);
      cnt_trig(10, c, f);
      chk("level trig off", 32'h2, c);
      $display("test delay done");
   endtask
   task automatic t_enc();
      int c;
      c = 0;
      encm = 2'h1;
      diff[0] = 1'h1;
      repeat (8) begin
         @(negedge core_clk);
         c += enc[0];
      end
      diff[0] = 1'h0;
      chk("encoder steps", 32'h1, c);
      encm = 2'h0;
      $display("test encoder done");
   endtask
   task automatic t_evt();
      ecfg.evt_type = ATC_EVT_LINE; ecfg.gate = ATC_GATE_FRAME;
      i_cam.frame(5);
      cyc_n(4);
      chk("lines in frame", 32'h5, fin);
      chk("live lines", 32'h5, live);
      ecfg.evt_type = ATC_EVT_FRAME; ecfg.gate = ATC_GATE_ACQ;
      acq = 1'h1;
      i_cam.frame(1);
      i_cam.frame(1);
      acq = 1'h0;
      cyc_n(4);
      chk("frames in acq", 32'h2, fin);
      ecfg.evt_type = ATC_EVT_USEC;
      acq = 1'h1;
      cyc_n(200);
      acq = 1'h0;
      cyc_n(4);
      chk("us in acq", 32'h1, {31'h0, fin >= 9 && fin <= 10});
      $display("test events done");
   endtask
   task automatic t_ttl();
      tdir = 2'h3; twa = 8'h5A; twb = 8'hC3;
      cyc_n(3);
      chk("oe", 32'h0, oen);
      chk("out a", 32'h5A, oa);
      chk("out b", 32'hC3, ob);
      tdir = 2'h0; pin_a = 8'h3C; pin_b = 8'h81;
      cyc_n(5);
      chk("live a", 32'h3C, ra);
      chk("live b", 32'h81, rb);
      latch[1] = 1'h1;
      cyc_n(5);
      pin_a = 8'h99;
      cyc_n(5);
      chk("latched a", 32'h3C, ra);
      latch[1] = 1'h0;
      cyc_n(5);
      chk("live a", 32'h99, ra);
      $display("test ttl done");
   endtask
   task automatic t_irq();
      irqn = 6'h04; irqe = 6'h01;
      cyc_n(3);
      chk("irq masked", 32'h0, irq);
      irqe = 6'h05;
      cyc_n(3);
      chk("irq on", 32'h1, irq);
      irqn = 6'h00;
      cyc_n(3);
      chk("irq off", 32'h0, irq);
      $display("test irq done");
   endtask
   // Main sequence
   initial begin
      acq = 1'h0; mfire = 1'h0; ast_en = 1'h0; iso_in = 2'h0; isol = 2'h0;
      latch = 2'h0; encm = 2'h0; tdir = 2'h0; diff = 4'h0; ccm = 4'h0;
      ccs = 4'h0; ccl = 4'h0; pin_a = 8'h00; pin_b = 8'h00; twa = 8'h00;
      twb = 8'h00; per = 32'h0; w0 = 32'h0; w1 = 32'h0; dly = 32'h0;
      irqe = 6'h00; irqn = 6'h00; tcfg = '0; ecfg = '0;
      msrc = ATC_MONO_SW; is0 = ATC_ISO_SW; is1 = ATC_ISO_SW;
      cyc_n(6);
      chk("reset oe", 32'h3, oen);
      chk("reset live", 32'h0, live);
      chk("reset irq", 32'h0, irq);
      sys_rst = 1'h0;
      cyc_n(2);
      t_levels();
      t_mono();
      t_astable();
      t_delay();
      t_enc();
      t_evt();
      t_ttl();
      t_irq();
      end_sim();
   end
endmodule // atc_tb_top
